// >>> hdl/cts_params.svh
// charger supervisor constants: offsets, fields, resets, timing.
// assumes one 40 MHz clock.
`ifndef CTS_PARAMS_SVH
`define CTS_PARAMS_SVH

// ***
// register offsets
// ***
`define CTS_ADDR_ADC_CONTROL      8'h15
`define CTS_ADDR_ADC_DISABLE      8'h16
`define CTS_ADDR_STATUS           8'h20
`define CTS_ADDR_FLAG             8'h21

// ***
// fields and reset values
// ***
`define CTS_ADC_EN_BIT            7
`define CTS_ADC_RATE_BIT          6
`define CTS_ADC_CONTROL_RESET     8'h30
`define CTS_ADC_DISABLE_RESET     8'h00
`define CTS_ALL_DISABLED          8'hFF
`define CTS_CH_END                4'h8
`define CTS_OTG_SUSPEND_BUS       3'h0
`define CTS_TS_COLD               3'h1
`define CTS_TS_HOT                3'h2
`define CTS_TS_NORMAL             3'h0

// ***
// timing
// ***
`define CTS_CLOCK_MHZ             40
`define CTS_ALERT_PULSE_US        256
`define CTS_SECOND_CYCLES         40000000
`define CTS_BLINK_HZ              1
`define CTS_PRECHARGE_HOURS       2
`define CTS_SECONDS_PER_HOUR      3600

`endif

// >>> hdl/cts_pkg.sv
// types shared by the charger supervisor.
// assumes nothing of its surroundings.
package cts_pkg;
    // adc sequencer states
    typedef enum logic [1:0] {
        CTS_ADC_IDLE,
        CTS_ADC_SEEK,
        CTS_ADC_CONV
    } cts_adc_state_type;
endpackage

// >>> hdl/cts_supervisor.sv
// supervisory logic of a two-cell boost charger: safety timers, adc
// sequencer, status pins and the host alert pulse.
// assumes inputs synchronous to clock;
// the serial interface core decodes the register port.
//
// Functional notes
// R1 - otg suspended outside temperature window, reported
// R2 - timer expiry sets fault bit, alerts host
// R3 - timer off when disabled; duration programmable
// R4 - regulation halves the timer rate
// R5 - double-time bit off: full rate, count kept
// R6 - faults and supplement mode freeze timer
// R7 - restart or phase change clears timer
// R8 - two-hour precharge timer, same rules
// R9 - one-shot completion clears adc enable
// R10 - no supply or no channels: skip, clear
// R11 - mode change interrupts, resumes same channel
// R12 - high-impedance mode powers adc when converting
// R13 - disabled channel keeps result, finishes current
// R14 - continuous all-disabled stays armed; one-shot clears
// R15 - done status only in one-shot mode
// R16 - adc ignores faults; disable stops instantly
// R17 - host stops via one-shot or channels
// R18 - supply good needs all four input conditions
// R19 - charge pin low, high, or 1 Hz blink
// R20 - alert is 256 us low pulse, power-up too
// R21 - status rise sets flag, read clears it
// R22 - charging needs register bit and pin low
// R23 - half rate advances every second tick
`timescale 1ns/1ps
`default_nettype none
`include "cts_params.svh"

module cts_supervisor
    import cts_pkg::*;
#(
    parameter int ALERT_CYCLES  = `CTS_ALERT_PULSE_US * `CTS_CLOCK_MHZ,
    parameter int SECOND_CYCLES = `CTS_SECOND_CYCLES,
    parameter int BLINK_CYCLES  = `CTS_SECOND_CYCLES / (2 * `CTS_BLINK_HZ)
) (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] irq_mask,
    input  wire logic       charge_enable_bit,
    input  wire logic       charge_enable_pin_n,
    input  wire logic       charge_in_progress,
    input  wire logic       charge_complete,
    input  wire logic       timer_enable,
    input  wire logic [4:0] fast_charge_duration,
    input  wire logic       double_time_enable,
    input  wire logic       input_current_regulation,
    input  wire logic       input_voltage_regulation,
    input  wire logic       junction_thermal_regulation,
    input  wire logic       charge_fault,
    input  wire logic       supplement_mode,
    input  wire logic       recharge_start,
    input  wire logic       battery_below_lowv,
    output logic            timer_fault_status,
    output logic            charging_enabled,
    input  wire logic       reverse_buck_enable,
    input  wire logic       battery_cold,
    input  wire logic       battery_hot,
    input  wire logic [2:0] bus_source_in,
    output logic            otg_active,
    output logic      [2:0] bus_source_type,
    output logic      [2:0] thermistor_condition,
    input  wire logic       bus_above_uvlo,
    input  wire logic       battery_above_uvlo,
    input  wire logic       bus_below_ovp,
    input  wire logic       bus_not_poor,
    input  wire logic       source_detect_done,
    input  wire logic       high_impedance_mode,
    input  wire logic       adc_mode_change,
    input  wire logic       adc_conv_done,
    output logic            adc_convert,
    output logic      [2:0] adc_channel,
    output logic            adc_capture,
    output logic            adc_power_request,
    output logic            supply_good_status,
    output logic            supply_good_pin_n_out,
    output logic            supply_good_pin_n_oe,
    output logic            charge_pin_out,
    output logic            charge_pin_oe,
    output logic            alert_pin_n
);

    // ***
    // charge enable, otg window, supply good
    // ***
    logic otg_suspend;                          // temperature outside otg window
    logic chg_en_prev_reg, chg_en_prev_next;    // for enable-toggle detection
    logic pre_prev_reg, pre_prev_next;          // precharge phase last cycle

    // R22 both enables
    assign charging_enabled = charge_enable_bit & ~charge_enable_pin_n;
    // R1 otg suspend
    assign otg_suspend = reverse_buck_enable & (battery_cold | battery_hot);
    assign otg_active  = reverse_buck_enable & ~otg_suspend;
    assign bus_source_type = otg_suspend ? `CTS_OTG_SUSPEND_BUS : bus_source_in;
    assign thermistor_condition = !otg_suspend ? `CTS_TS_NORMAL :
                                  (battery_cold ? `CTS_TS_COLD : `CTS_TS_HOT);
    // R18 supply good
    assign supply_good_status = bus_above_uvlo & bus_below_ovp & bus_not_poor & source_detect_done;
    assign supply_good_pin_n_out = 1'b0;
    assign supply_good_pin_n_oe  = supply_good_status;

    // ***
    // safety timers
    // ***
    logic [25:0] presc_reg, presc_next;         // cycles within one second
    logic [16:0] secs_reg, secs_next;           // elapsed timer seconds
    logic        half_reg, half_next;           // alternate-tick phase
    logic        tfault_reg, tfault_next;       // sticky timer fault
    logic        sec_tick;                      // one-second timebase
    logic        restart;                       // clears the count
    logic        running;                       // timer advancing allowed
    logic [16:0] limit;                         // expiry in seconds

    always_comb begin
        // limit: fixed precharge or programmed fast charge
        // R8 precharge limit
        limit = battery_below_lowv ? 17'(`CTS_PRECHARGE_HOURS * `CTS_SECONDS_PER_HOUR)
                                   : 17'(fast_charge_duration * `CTS_SECONDS_PER_HOUR);
        // R7 restart conditions
        restart = (charging_enabled & ~chg_en_prev_reg) | recharge_start |
                  (battery_below_lowv != pre_prev_reg);
        // R3 disabled timer / R6 frozen
        running = timer_enable & charging_enabled & charge_in_progress &
                  ~charge_fault & ~supplement_mode & ~tfault_reg;
        sec_tick = (presc_reg == 26'(SECOND_CYCLES - 1));
        chg_en_prev_next = charging_enabled;
        pre_prev_next    = battery_below_lowv;
        presc_next = sec_tick ? 26'h0 : presc_reg + 26'h1;
        secs_next  = secs_reg;
        half_next  = half_reg;
        tfault_next = tfault_reg;
        if (restart) begin
            secs_next   = 17'h0;
            half_next   = 1'b0;
            tfault_next = 1'b0;
        end else if (running && sec_tick) begin
            // R4 half rate in regulation, R5 unless double-time off, R23 alternate ticks
            if (double_time_enable && (input_current_regulation || input_voltage_regulation ||
                                       junction_thermal_regulation)) begin
                half_next = ~half_reg;
                if (half_reg) begin
                    secs_next = secs_reg + 17'h1;
                end
            end else begin
                secs_next = secs_reg + 17'h1;
            end
        end
        // R2 expiry sets fault
        if (!restart && running && secs_reg >= limit) begin
            tfault_next = 1'b1;
        end
    end

    // register the timer group
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            presc_reg       <= 26'h0;
            secs_reg        <= 17'h0;
            half_reg        <= 1'b0;
            tfault_reg      <= 1'b0;
            chg_en_prev_reg <= 1'b0;
            pre_prev_reg    <= 1'b0;
        end else begin
            presc_reg       <= presc_next;
            secs_reg        <= secs_next;
            half_reg        <= half_next;
            tfault_reg      <= tfault_next;
            chg_en_prev_reg <= chg_en_prev_next;
            pre_prev_reg    <= pre_prev_next;
        end
    end
    assign timer_fault_status = tfault_reg;

    // ***
    // adc sequencer
    // ***
    cts_adc_state_type st_reg, st_next;         // sequencer state
    logic [7:0] ctl_reg, ctl_next;              // adc control register
    logic [7:0] dis_reg, dis_next;              // channel disable register
    logic [3:0] ch_reg, ch_next;                // current channel, 8 = cycle end
    logic       done_reg, done_next;            // one-shot done status
    logic [4:0] seek;                           // {found, index} of next channel

    // first enabled channel from start on; a late disable bit
    // spares the channel already converting
    function automatic logic [4:0] next_channel(input logic [7:0] dis, input logic [3:0] start);
        logic [4:0] res;
        res = 5'h0;
        for (int i = 7; i >= 0; i--) begin
            if (4'(i) >= start && !dis[i]) begin
                res = {1'b1, 4'(i)};
            end
        end
        return res;
    endfunction

    always_comb begin
        st_next   = st_reg;
        ctl_next  = ctl_reg;
        dis_next  = dis_reg;
        ch_next   = ch_reg;
        done_next = done_reg;
        seek      = next_channel(dis_reg, ch_reg);
        case (st_reg)
            CTS_ADC_IDLE: begin
                if (ctl_reg[`CTS_ADC_EN_BIT]) begin
                    st_next = CTS_ADC_SEEK;
                    ch_next = 4'h0;
                end
            end
            CTS_ADC_SEEK: begin
                if (adc_mode_change) begin
                    // R11 held until mode change ends
                    st_next = CTS_ADC_SEEK;
                end else if (!bus_above_uvlo && !battery_above_uvlo) begin
                    // R10 no supply: skip quietly
                    ctl_next[`CTS_ADC_EN_BIT] = 1'b0;
                    st_next = CTS_ADC_IDLE;
                end else if (seek[4]) begin
                    ch_next = seek[3:0];
                    st_next = CTS_ADC_CONV;
                end else if (dis_reg == `CTS_ALL_DISABLED) begin
                    // R14 armed in continuous, cleared in one-shot (R10 no done)
                    ch_next = 4'h0;
                    if (ctl_reg[`CTS_ADC_RATE_BIT]) begin
                        ctl_next[`CTS_ADC_EN_BIT] = 1'b0;
                        st_next = CTS_ADC_IDLE;
                    end
                end else if (ctl_reg[`CTS_ADC_RATE_BIT]) begin
                    // R9 one-shot complete clears enable
                    // R15 done only in one-shot
                    ctl_next[`CTS_ADC_EN_BIT] = 1'b0;
                    done_next = 1'b1;
                    st_next = CTS_ADC_IDLE;
                end else begin
                    ch_next = 4'h0;
                end
            end
            CTS_ADC_CONV: begin
                // R11 interrupted channel is redone after the change
                if (adc_mode_change) begin
                    st_next = CTS_ADC_SEEK;
                end else if (adc_conv_done) begin
                    ch_next = ch_reg + 4'h1;
                    st_next = CTS_ADC_SEEK;
                end
            end
            default: begin
                st_next = CTS_ADC_IDLE;
            end
        endcase
        // R15 continuous reads done as zero
        if (!ctl_reg[`CTS_ADC_RATE_BIT]) begin
            done_next = 1'b0;
        end
        if (reg_write && reg_addr == `CTS_ADDR_ADC_DISABLE) begin
            dis_next = reg_wdata;
        end
        if (reg_write && reg_addr == `CTS_ADDR_ADC_CONTROL) begin
            ctl_next = reg_wdata;
            if (!reg_wdata[`CTS_ADC_EN_BIT]) begin
                // R16 host disable stops at once
                st_next = CTS_ADC_IDLE;
            end else if (!ctl_reg[`CTS_ADC_EN_BIT]) begin
                done_next = 1'b0;
            end
        end
    end

    // register the adc group
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            st_reg   <= CTS_ADC_IDLE;
            ctl_reg  <= `CTS_ADC_CONTROL_RESET;
            dis_reg  <= `CTS_ADC_DISABLE_RESET;
            ch_reg   <= 4'h0;
            done_reg <= 1'b0;
        end else begin
            st_reg   <= st_next;
            ctl_reg  <= ctl_next;
            dis_reg  <= dis_next;
            ch_reg   <= ch_next;
            done_reg <= done_next;
        end
    end

    // R13 results load only on a finished conversion;
    // disabled channels keep their last value
    assign adc_convert = (st_reg == CTS_ADC_CONV);
    assign adc_channel = ch_reg[2:0];
    assign adc_capture = adc_convert & adc_conv_done & ~adc_mode_change;
    // R12 always powered outside high-impedance mode; in it, powered only while sequencing
    assign adc_power_request = (st_reg != CTS_ADC_IDLE) | ~high_impedance_mode;

    // ***
    // status, flags, alert pulse, charge pin
    // ***
    logic [7:0]  stat;                          // live status vector
    logic [7:0]  stat_prev_reg, stat_prev_next; // last cycle status
    logic [7:0]  flag_reg, flag_next;           // sticky flags
    logic [7:0]  rise;                          // rising edges of status
    logic [13:0] alert_reg, alert_next;         // pulse cycles left
    logic        ready_reg, ready_next;         // up after reset: interface ready
    logic [24:0] blink_cnt_reg, blink_cnt_next; // half-period counter
    logic        blink_reg, blink_next;         // 1 Hz square wave
    logic [7:0]  rdata_next;                    // read data

    always_comb begin
        stat = {ready_reg, junction_thermal_regulation, input_voltage_regulation,
                input_current_regulation, otg_suspend, done_reg, tfault_reg, supply_good_status};
        rise = stat & ~stat_prev_reg;
        stat_prev_next = stat;
        ready_next = 1'b1;
        // R21 read clears, a new rise wins over the clear
        flag_next = flag_reg;
        if (reg_read && reg_addr == `CTS_ADDR_FLAG) begin
            flag_next = 8'h00;
        end
        flag_next = flag_next | rise;
        // R20 fixed low pulse, retriggered
        // R2 expiry alerts the same way
        if ((rise & ~irq_mask) != 8'h00) begin
            alert_next = 14'(ALERT_CYCLES);
        end else if (alert_reg != 14'h0) begin
            alert_next = alert_reg - 14'h1;
        end else begin
            alert_next = 14'h0;
        end
        // blink timebase
        if (blink_cnt_reg == 25'(BLINK_CYCLES - 1)) begin
            blink_cnt_next = 25'h0;
            blink_next = ~blink_reg;
        end else begin
            blink_cnt_next = blink_cnt_reg + 25'h1;
            blink_next = blink_reg;
        end
        case (reg_addr)
            `CTS_ADDR_ADC_CONTROL: rdata_next = ctl_reg;
            `CTS_ADDR_ADC_DISABLE: rdata_next = dis_reg;
            `CTS_ADDR_STATUS:      rdata_next = stat;
            `CTS_ADDR_FLAG:        rdata_next = flag_reg;
            default:               rdata_next = 8'h00;
        endcase
    end

    // register the status group
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stat_prev_reg <= 8'h00;
            flag_reg      <= 8'h00;
            alert_reg     <= 14'h0;
            ready_reg     <= 1'b0;
            blink_cnt_reg <= 25'h0;
            blink_reg     <= 1'b0;
            reg_rdata     <= 8'h00;
        end else begin
            stat_prev_reg <= stat_prev_next;
            flag_reg      <= flag_next;
            alert_reg     <= alert_next;
            ready_reg     <= ready_next;
            blink_cnt_reg <= blink_cnt_next;
            blink_reg     <= blink_next;
            reg_rdata     <= rdata_next;
        end
    end

    assign alert_pin_n = (alert_reg == 14'h0);
    // R19 charge indicator: blink on charge fault, timer fault or otg suspend, low while charging
    assign charge_pin_out = 1'b0;
    assign charge_pin_oe  = (charge_fault | tfault_reg | otg_suspend) ? blink_reg :
                            (charging_enabled & charge_in_progress & ~charge_complete);

    // ***
    // assertions
    // ***
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    a_otg_bus_zero: assert property (otg_suspend |-> bus_source_type == 3'h0 && !otg_active) // R1
        else $error("otg bus type not zero");
    a_timer_fault_set: assert property (running && !restart && secs_reg >= limit |=> tfault_reg) // R2
        else $error("no timer fault");
    a_timer_frozen: assert property (!running && !restart |=> secs_reg == $past(secs_reg)) // R6
        else $error("timer moved");
    a_timer_restart: assert property (restart |=> secs_reg == 17'h0 && !tfault_reg) // R7
        else $error("timer not cleared");
    a_adc_stop: assert property (reg_write && reg_addr == 8'h15 && !reg_wdata[7] |=> st_reg == CTS_ADC_IDLE) // R16
        else $error("adc not stopped");
    a_oneshot_clear: assert property ($rose(done_reg) |-> !ctl_reg[7] && st_reg == CTS_ADC_IDLE) // R9
        else $error("enable left set");
    a_cont_done_zero: assert property (!ctl_reg[6] |=> !done_reg) // R15
        else $error("done in continuous");
    a_alert_width: assert property ($fell(alert_pin_n) |-> !alert_pin_n [*8]) // R20
        else $error("alert pulse too short");
    a_flag_rise: assert property ((stat & ~stat_prev_reg) != 8'h00 |=> (flag_reg & $past(rise)) == $past(rise)) // R21
        else $error("flag not set");
    a_supply_pin: assert property (supply_good_pin_n_oe == supply_good_status) // R18
        else $error("supply pin wrong");

endmodule
`default_nettype wire

// >>> tb/cts_adc_model.sv
// analog front end model answering the adc sequencer.
// assumes adc_convert comes from the supervisor on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cts_adc_model #(
    parameter int DELAY = 3 // cycles per conversion
) (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic adc_convert,
    output logic      adc_conv_done
);
    // ***
    // conversion timer
    // ***
    int count_reg; // cycles spent on the current channel
    // dropping convert restarts the count
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            count_reg     <= 0;
            adc_conv_done <= 1'b0;
        end else begin
            adc_conv_done <= adc_convert && count_reg == DELAY - 1;
            count_reg     <= (adc_convert && count_reg < DELAY - 1) ? count_reg + 1 : 0;
        end
    end
endmodule
`default_nettype wire

// >>> tb/tb_charger_timer_adc_status_logic.sv
// self-checking bench for the charger supervisor.
// assumes the adc model and a shortened second.
`timescale 1ns/1ps
`default_nettype none
`include "cts_params.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
    $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module tb_charger_timer_adc_status_logic;
    localparam int SEC = 4; // shortened second, so an hour is 14400 cycles
    localparam int HOUR = `CTS_SECONDS_PER_HOUR * SEC;
    logic clock = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0, b;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, irq_mask = 8'h00, rd, reg_rdata;
    logic [3:0] sg = 4'h0; // uvlo, ovp, poor source, detection done
    logic [4:0] fast_charge_duration = 5'h00;
    logic [2:0] bus_source_in = 3'h0, bus_source_type, thermistor_condition;
    logic charge_enable_bit = 1'b0, charge_enable_pin_n = 1'b1, charge_in_progress = 1'b0;
    logic charge_complete = 1'b0, timer_enable = 1'b0, double_time_enable = 1'b0, charge_fault = 1'b0;
    logic input_current_regulation = 1'b0, input_voltage_regulation = 1'b0;
    logic junction_thermal_regulation = 1'b0, battery_below_lowv = 1'b0, reverse_buck_enable = 1'b0;
    logic battery_cold = 1'b0, battery_hot = 1'b0, battery_above_uvlo = 1'b0;
    logic supplement_mode = 1'b0, recharge_start = 1'b0;
    logic timer_fault_status, charging_enabled, otg_active, adc_convert, adc_conv_done;
    logic supply_good_status, supply_good_pin_n_oe, charge_pin_oe, alert_pin_n;
    int err_total = 0, n_compared = 0, cycles = 0;
    cts_supervisor #(.ALERT_CYCLES(16), .SECOND_CYCLES(SEC), .BLINK_CYCLES(8)) DUT (
        .clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq_mask,
        .charge_enable_bit, .charge_enable_pin_n, .charge_in_progress, .charge_complete,
        .timer_enable, .fast_charge_duration, .double_time_enable, .input_current_regulation,
        .input_voltage_regulation, .junction_thermal_regulation, .charge_fault, .supplement_mode,
        .recharge_start, .battery_below_lowv, .timer_fault_status, .charging_enabled,
        .reverse_buck_enable, .battery_cold, .battery_hot, .bus_source_in, .otg_active,
        .bus_source_type, .thermistor_condition, .bus_above_uvlo(sg[0]), .battery_above_uvlo,
        .bus_below_ovp(sg[1]), .bus_not_poor(sg[2]), .source_detect_done(sg[3]),
        .high_impedance_mode(1'b0), .adc_mode_change(1'b0), .adc_conv_done, .adc_convert,
        .adc_channel(), .adc_capture(), .adc_power_request(), .supply_good_status,
        .supply_good_pin_n_out(), .supply_good_pin_n_oe, .charge_pin_out(), .charge_pin_oe, .alert_pin_n);
    cts_adc_model #(.DELAY(3)) adc (.clock, .reset, .adc_convert, .adc_conv_done);
    // ***
    // clock, timeout and register tasks
    // ***
    always #12.5 clock = ~clock;
    // a hang counts as a mismatch
    always @(posedge clock) begin
        cycles++;
        if (cycles == 70000) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // idle cycle keeps strobes apart
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'b1;
        @(negedge clock);
        reg_write = 1'b0;
        @(negedge clock);
    endtask
    task automatic rdr(input logic [7:0] a);
        reg_addr = a;
        reg_read = 1'b1;
        @(negedge clock);
        reg_read = 1'b0;
        rd = reg_rdata;
        @(negedge clock);
    endtask
    // ***
    // main sequence
    // ***
    initial begin
        repeat (12) @(negedge clock);
        reset = 1'b0;
        repeat (3) @(negedge clock);
        `CHK("alert_low", 1'b0, alert_pin_n)
        repeat (17) @(negedge clock);
        `CHK("alert_end", 1'b1, alert_pin_n)
        rdr(`CTS_ADDR_ADC_CONTROL);
        `CHK("adc_control", `CTS_ADC_CONTROL_RESET, rd)
        rdr(`CTS_ADDR_ADC_DISABLE);
        `CHK("adc_disable", `CTS_ADC_DISABLE_RESET, rd)
        wr(8'h7F, 8'hA5);
        rdr(8'h7F);
        `CHK("unmapped", 8'h00, rd)
        rdr(`CTS_ADDR_FLAG);
        `CHK("flag_ready", 1'b1, rd[7])
        rdr(`CTS_ADDR_FLAG);
        `CHK("flag_clear", 1'b0, rd[7])
        irq_mask = 8'h01;
        for (int i = 0; i < 4; i++) begin
            sg = 4'hF ^ (4'h1 << i);
            @(negedge clock);
            `CHK("sg_partial", 1'b0, supply_good_status)
        end
        sg = 4'hF;
        @(negedge clock);
        `CHK("sg_pin", 1'b1, supply_good_pin_n_oe)
        `CHK("alert_masked", 1'b1, alert_pin_n)
        rdr(`CTS_ADDR_FLAG);
        `CHK("flag_masked", 8'h01, rd & 8'h05)
        wr(`CTS_ADDR_ADC_CONTROL, 8'h80);
        repeat (40) @(negedge clock);
        rdr(`CTS_ADDR_STATUS);
        `CHK("done_cont", 1'b0, rd[2])
        rdr(`CTS_ADDR_ADC_CONTROL);
        `CHK("en_cont", 1'b1, rd[7])
        wr(`CTS_ADDR_ADC_CONTROL, 8'hC0);
        for (int i = 0; i < 100 && rd[7]; i++) rdr(`CTS_ADDR_ADC_CONTROL);
        `CHK("en_oneshot", 1'b0, rd[7])
        rdr(`CTS_ADDR_FLAG);
        `CHK("done_flag", 1'b1, rd[2])
        wr(`CTS_ADDR_ADC_DISABLE, 8'hFF);
        wr(`CTS_ADDR_ADC_CONTROL, 8'hC0);
        @(negedge clock);
        rdr(`CTS_ADDR_ADC_CONTROL);
        `CHK("en_all_off", 1'b0, rd[7])
        sg = 4'hE;
        wr(`CTS_ADDR_ADC_DISABLE, 8'h00);
        wr(`CTS_ADDR_ADC_CONTROL, 8'hC0);
        @(negedge clock);
        rdr(`CTS_ADDR_ADC_CONTROL);
        `CHK("en_no_supply", 1'b0, rd[7])
        rdr(`CTS_ADDR_FLAG);
        `CHK("no_done", 1'b0, rd[2])
        battery_above_uvlo = 1'b1;
        wr(`CTS_ADDR_ADC_DISABLE, 8'hFF);
        wr(`CTS_ADDR_ADC_CONTROL, 8'h80);
        repeat (10) @(negedge clock);
        rdr(`CTS_ADDR_ADC_CONTROL);
        `CHK("armed", 1'b1, rd[7])
        wr(`CTS_ADDR_ADC_DISABLE, 8'h00);
        repeat (3) @(negedge clock);
        `CHK("convert_on", 1'b1, adc_convert)
        wr(`CTS_ADDR_ADC_CONTROL, 8'h00);
        `CHK("convert_off", 1'b0, adc_convert)
        reverse_buck_enable = 1'b1;
        bus_source_in = 3'h5;
        for (int i = 0; i < 3; i++) begin
            {battery_hot, battery_cold} = 2'(i);
            @(negedge clock);
            `CHK("otg", i == 0, otg_active)
            `CHK("bus_type", (i == 0) ? 3'h5 : 3'h0, bus_source_type)
            `CHK("ts", 3'(i), thermistor_condition)
        end
        {reverse_buck_enable, battery_hot} = 2'h0;
        charge_enable_bit = 1'b1;
        charge_in_progress = 1'b1;
        @(negedge clock);
        `CHK("chg_pin_high", 1'b0, charging_enabled)
        `CHK("stat_off", 1'b0, charge_pin_oe)
        charge_enable_pin_n = 1'b0;
        fast_charge_duration = 5'h01;
        @(negedge clock);
        `CHK("chg_en", 1'b1, charging_enabled)
        `CHK("stat_low", 1'b1, charge_pin_oe)
        repeat (HOUR + 600) @(negedge clock);
        `CHK("tmr_off", 1'b0, timer_fault_status)
        timer_enable = 1'b1;
        double_time_enable = 1'b1;
        for (int i = 0; i < 3; i++) begin
            {junction_thermal_regulation, input_voltage_regulation, input_current_regulation} = 3'h1 << i;
            repeat (HOUR / 6) @(negedge clock);
        end
        {junction_thermal_regulation, input_voltage_regulation, input_current_regulation} = 3'h0;
        charge_fault = 1'b1;
        repeat (1000) @(negedge clock);
        {charge_fault, supplement_mode} = 2'h1;
        repeat (1000) @(negedge clock);
        supplement_mode = 1'b0;
        repeat (HOUR * 3 / 4 - 100) @(negedge clock);
        `CHK("tmr_early", 1'b0, timer_fault_status)
        repeat (200) @(negedge clock);
        `CHK("tmr_fault", 1'b1, timer_fault_status)
        rdr(`CTS_ADDR_FLAG);
        `CHK("tmr_flag", 1'b1, rd[1])
        b = charge_pin_oe;
        repeat (8) @(negedge clock);
        `CHK("blink", ~b, charge_pin_oe)
        charge_enable_bit = 1'b0;
        @(negedge clock);
        charge_enable_bit = 1'b1;
        double_time_enable = 1'b0;
        input_current_regulation = 1'b1;
        @(negedge clock);
        `CHK("tmr_restart", 1'b0, timer_fault_status)
        repeat (HOUR / 2) @(negedge clock);
        battery_below_lowv = 1'b1;
        @(negedge clock);
        battery_below_lowv = 1'b0;
        repeat (HOUR - 100) @(negedge clock);
        `CHK("tmr_phase", 1'b0, timer_fault_status)
        repeat (200) @(negedge clock);
        `CHK("tmr_full_rate", 1'b1, timer_fault_status)
        recharge_start = 1'b1;
        @(negedge clock);
        recharge_start = 1'b0;
        charge_in_progress = 1'b0;
        charge_complete = 1'b1;
        @(negedge clock);
        `CHK("stat_done", 1'b0, charge_pin_oe)
        report_and_stop();
    end
endmodule
`default_nettype wire
